// >>> crosspoint_defines.svh
`ifndef CROSSPOINT_DEFINES_SVH
`define CROSSPOINT_DEFINES_SVH

// ****************************************
// Geometry
// ****************************************
`define CPL_OUTPUTS      8
`define CPL_INPUTS       8
`define CPL_SLOT_BITS    5
`define CPL_SEL_BITS     3
`define CPL_INDEX_BITS   3
`define CPL_SR_BITS      40

// ****************************************
// Slot field positions
// ****************************************
`define CPL_SLOT_EN_POS  4
`define CPL_SLOT_RSV_POS 3
`define CPL_SLOT_SEL_LSB 0

// ****************************************
// Values
// ****************************************
`define CPL_RSV_VALUE    1'h1
`define CPL_SR_RESET     40'h00_0000_0000
`define CPL_RANK2_RESET  40'h00_0000_0000

`endif

// >>> crosspoint_pkg.sv
`default_nettype none

package crosspoint_pkg;
  typedef logic [2:0] sel_t;

  typedef struct packed {
    logic enable;
    logic reserved;
    sel_t source;
  } slot_s;

  typedef enum logic {
    LOAD_SERIAL,
    LOAD_PARALLEL
  } load_mode_e;
endpackage

`default_nettype wire

// >>> crosspoint_program_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "crosspoint_defines.svh"

// Summary of operation
// - Serial mode shifts data on clock fall
// - Forty-bit register, serial out after forty
// - Parallel mode, clock low writes nibble slot
// - Three-bit index picks the written slot
// - Clock pin: shift edge or level enable
// - Update low with chip selected makes second rank follow
// - Reset pin low disables all outputs
// - Reset pin spares the first rank
// - Parallel write forces reserved bit one
// - Serial out always shows register MSB
// - Slot order enable, reserved, select MSB-first
module crosspoint_program_logic
  import crosspoint_pkg::*;
(
  input  wire logic                           clk_sys_i,
  input  wire logic                           rstn_i,
  input  wire logic                           chip_select_n_i,
  input  wire logic                           load_mode_select_i,
  input  wire logic                           prog_clk_i,
  input  wire logic                           serial_in_i,
  input  wire logic [3:0]                     parallel_nibble_i,
  input  wire logic [`CPL_INDEX_BITS-1:0]     parallel_out_index_i,
  input  wire logic                           update_n_i,
  input  wire logic                           rank2_reset_n_i,
  output logic                                serial_out_o,
  output logic [`CPL_OUTPUTS-1:0]             output_enable_o,
  output logic [`CPL_OUTPUTS*`CPL_INPUTS-1:0] source_onehot_o
);

  localparam int SR_BITS   = `CPL_SR_BITS;
  localparam int SLOT_BITS = `CPL_SLOT_BITS;

  logic [SR_BITS-1:0] first_rank;
  logic             prog_clk_q;
  logic             prog_clk_fall;
  load_mode_e       mode;
  logic             selected;
  logic             serial_shift;
  logic             parallel_load;
  slot_s            next_slot;

  rank_link_if link ();

  // ****************************************
  // Pin decode
  // ****************************************
  assign mode     = load_mode_e'(load_mode_select_i);
  assign selected = !chip_select_n_i;

  // Edge of the sampled pin; inputs already share our clock
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      prog_clk_q <= 1'h0;
    end else begin
      prog_clk_q <= prog_clk_i;
    end
  end

  assign prog_clk_fall = prog_clk_q && !prog_clk_i;

  // Same pin: edge in serial mode, level in parallel mode
  assign serial_shift  = selected && (mode == LOAD_SERIAL)
                         && prog_clk_fall;
  assign parallel_load = selected && (mode == LOAD_PARALLEL)
                         && !prog_clk_i;

  // Reserved bit comes from inside, never from the pins
  always_comb begin
    next_slot          = '0;
    next_slot.enable   = parallel_nibble_i[3];
    next_slot.reserved = `CPL_RSV_VALUE;
    next_slot.source   = parallel_nibble_i[2:0];
  end

  // ****************************************
  // First rank
  // ****************************************
  // Pin reset is not in this process, so the first rank survives it
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      first_rank <= `CPL_SR_RESET;
    end else if (serial_shift) begin
      first_rank <= {first_rank[SR_BITS-2:0],
                     serial_in_i};
    end else if (parallel_load) begin
      first_rank[SLOT_BITS*parallel_out_index_i +: SLOT_BITS]
        <= next_slot;
    end
  end

  assign serial_out_o     = first_rank[SR_BITS-1];

  // ****************************************
  // Second rank link
  // ****************************************
  // Held-low update passes intermediate shift states on to the array
  assign link.first_rank = first_rank;
  assign link.transfer   = selected && !update_n_i
                           && rank2_reset_n_i;
  assign link.clear      = !rank2_reset_n_i;

  second_rank_decode u_rank2 (
    .clk_sys_i       (clk_sys_i),
    .rstn_i          (rstn_i),
    .link            (link.dst),
    .output_enable_o (output_enable_o),
    .source_onehot_o (source_onehot_o)
  );

  // ****************************************
  // Checks
  // ****************************************
  serial_shift_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    serial_shift |=> first_rank ==
      {$past(first_rank[SR_BITS-2:0]), $past(serial_in_i)})
    else $error("serial bit not shifted on clock fall");

  no_rise_shift_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (selected && mode == LOAD_SERIAL && !prog_clk_fall)
      |=> $stable(first_rank))
    else $error("serial register moved without a clock fall");

  par_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    parallel_load |=>
      first_rank[SLOT_BITS*$past(parallel_out_index_i) +: SLOT_BITS]
      == {$past(parallel_nibble_i[3]), 1'h1,
          $past(parallel_nibble_i[2:0])})
    else $error("parallel slot not written");

  par_rsv_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (parallel_load && parallel_out_index_i == 3'h0) |=> first_rank[3])
    else $error("reserved bit not forced to one");

  par_level_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (selected && mode == LOAD_PARALLEL && prog_clk_i) |=> $stable(first_rank))
    else $error("parallel load while clock high");

  chip_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    chip_select_n_i |=> $stable(first_rank))
    else $error("first rank changed with chip deselected");

  keep_first_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (!rank2_reset_n_i && chip_select_n_i) |=> first_rank == $past(first_rank))
    else $error("pin reset disturbed the first rank");

  dout_msb_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    serial_out_o == first_rank[SR_BITS-1])
    else $error("serial out not the register MSB");

  transfer_out_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (link.transfer && first_rank[4:3] == 2'h3) |=>
      output_enable_o[0] && source_onehot_o[$past(first_rank[2:0])])
    else $error("transparent latch did not route output 0");

  serial_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    serial_shift ##1 serial_shift);

  parallel_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    parallel_load ##1 link.transfer);

  update_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    link.transfer && output_enable_o == '0 ##1 output_enable_o != '0);

endmodule

`default_nettype wire

// >>> prog_controller.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Far-side controller driving the pins
// ****************************************
module prog_controller (
  input  wire logic       clk_sys_i,
  output logic            cs_n_o,
  output logic            mode_o,
  output logic            pclk_o,
  output logic            sdata_o,
  output logic [3:0]      nibble_o,
  output logic [2:0]      index_o,
  output logic            update_n_o,
  output logic            r2_reset_n_o
);
  logic upd_idle;

  // Clock idles high so parallel mode never loads by accident
  initial begin
    cs_n_o       = 1'h0;
    mode_o       = 1'h0;
    pclk_o       = 1'h1;
    sdata_o      = 1'h0;
    nibble_o     = 4'h0;
    index_o      = 3'h0;
    update_n_o   = 1'h1;
    r2_reset_n_o = 1'h1;
    upd_idle     = 1'h1;
  end

  task automatic levels(input logic cs, input logic upd);
    @(posedge clk_sys_i);
    cs_n_o     <= cs;
    update_n_o <= upd;
    upd_idle    = upd;
  endtask

  // Data held only while clock is low, then inverted
  task automatic shift_bit(input logic d);
    @(posedge clk_sys_i);
    mode_o  <= 1'h0;
    pclk_o  <= 1'h0;
    sdata_o <= d;
    @(posedge clk_sys_i);
    pclk_o  <= 1'h1;
    sdata_o <= ~d;
  endtask

  task automatic par_write(input logic [2:0] i, input logic [3:0] n);
    @(posedge clk_sys_i);
    mode_o   <= 1'h1;
    index_o  <= i;
    nibble_o <= n;
    pclk_o   <= 1'h0;
    @(posedge clk_sys_i);
    pclk_o   <= 1'h1;
    index_o  <= ~i;
    nibble_o <= ~n;
  endtask

  // Update stays high while shifting unless a level is chosen
  task automatic strobe(input logic clr);
    @(posedge clk_sys_i);
    if (clr) r2_reset_n_o <= 1'h0;
    else update_n_o <= 1'h0;
    @(posedge clk_sys_i);
    r2_reset_n_o <= 1'h1;
    update_n_o   <= upd_idle;
  endtask
endmodule

`default_nettype wire

// >>> rank_link_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "crosspoint_defines.svh"

interface rank_link_if;
  logic [`CPL_SR_BITS-1:0] first_rank;
  logic                    transfer;
  logic                    clear;

  modport src (output first_rank, output transfer, output clear);
  modport dst (input first_rank, input transfer, input clear);
endinterface

`default_nettype wire

// >>> second_rank_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "crosspoint_defines.svh"

module second_rank_decode
  import crosspoint_pkg::*;
(
  input  wire logic                       clk_sys_i,
  input  wire logic                       rstn_i,
  rank_link_if.dst                        link,
  output logic [`CPL_OUTPUTS-1:0]         output_enable_o,
  output logic [`CPL_OUTPUTS*`CPL_INPUTS-1:0] source_onehot_o
);

  logic [`CPL_SR_BITS-1:0]              rank2;
  logic [`CPL_SR_BITS-1:0]              next_rank2;
  logic [`CPL_OUTPUTS-1:0]              next_enable;
  logic [`CPL_OUTPUTS*`CPL_INPUTS-1:0]  next_onehot;

  function automatic logic [`CPL_INPUTS-1:0] decode_slot(input slot_s s);
    logic [`CPL_INPUTS-1:0] v;
    v = '0;
    if (s.enable) begin
      v[s.source] = 1'h1;
    end
    return v;
  endfunction

  // ****************************************
  // Second rank
  // ****************************************
  always_comb begin
    next_rank2 = rank2;
    if (link.clear) begin
      next_rank2 = `CPL_RANK2_RESET;
    end else if (link.transfer) begin
      next_rank2 = link.first_rank;
    end
  end

  generate
    for (genvar k = 0; k < `CPL_OUTPUTS; k++) begin : g_dec
      slot_s s;
      assign s = next_rank2[k*`CPL_SLOT_BITS +: `CPL_SLOT_BITS];
      assign next_enable[k] = s.enable;
      assign next_onehot[k*`CPL_INPUTS +: `CPL_INPUTS] = decode_slot(s);
    end
  endgenerate

  // Decode registered from the next value so pins match the latch
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rank2           <= `CPL_RANK2_RESET;
      output_enable_o <= '0;
      source_onehot_o <= '0;
    end else begin
      rank2           <= next_rank2;
      output_enable_o <= next_enable;
      source_onehot_o <= next_onehot;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  clear_disables_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    link.clear |=> (output_enable_o == '0) && (source_onehot_o == '0))
    else $error("outputs not disabled after second rank clear");

  follow_rank_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (link.transfer && !link.clear) |=> rank2 == $past(link.first_rank))
    else $error("second rank did not follow first rank");

  onehot_dec_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $onehot0(source_onehot_o[7:0])
      && (output_enable_o[0] == |source_onehot_o[7:0]))
    else $error("output 0 decode not one of eight or none");

  hold_rank_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (!link.transfer && !link.clear) |=> $stable(rank2) && $stable(output_enable_o))
    else $error("second rank changed without transfer");

  clear_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    output_enable_o != '0 ##1 link.clear ##1 output_enable_o == '0);

endmodule

`default_nettype wire

// >>> tb_crosspoint_program_logic.sv
`timescale 1ns/1ps
`default_nettype none

module tb_crosspoint_program_logic;
  logic        clk_sys_i = 1'h0;
  logic        rstn_i    = 1'h0;
  logic        cs_n, mode, pclk, sdata, upd_n, r2_n, sout;
  logic [3:0]  nib;
  logic [2:0]  idx;
  logic [7:0]  oe;
  logic [63:0] oh;
  logic [15:0] rnd = 16'h003D;
  int          error_cnt    = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  bit          fr_q[$];
  bit          r2_q[$];
  bit          cs_off, upd_low;

  crosspoint_program_logic crosspoint_program_logic_i (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .chip_select_n_i(cs_n),
    .load_mode_select_i(mode), .prog_clk_i(pclk), .serial_in_i(sdata),
    .parallel_nibble_i(nib), .parallel_out_index_i(idx),
    .update_n_i(upd_n), .rank2_reset_n_i(r2_n), .serial_out_o(sout),
    .output_enable_o(oe), .source_onehot_o(oh));

  prog_controller prog_controller_i (
    .clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .mode_o(mode), .pclk_o(pclk),
    .sdata_o(sdata), .nibble_o(nib), .index_o(idx), .update_n_o(upd_n),
    .r2_reset_n_o(r2_n));

  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic test_done();
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what);
    logic [63:0] e_oh;
    logic [7:0]  e_en;
    int          s;
    @(negedge clk_sys_i);
    e_oh = 64'h0;
    for (int k = 0; k < 8; k++) begin
      e_en[k] = r2_q[5*k+4];
      s = r2_q[5*k] + 2 * r2_q[5*k+1] + 4 * r2_q[5*k+2];
      if (e_en[k]) e_oh[8*k+s] = 1'h1;
    end
    total_checks++;
    if (sout !== fr_q[39] || oe !== e_en || oh !== e_oh) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic sbit(input bit d);
    prog_controller_i.shift_bit(d);
    if (!cs_off) begin
      fr_q.push_front(d);
      void'(fr_q.pop_back());
    end
    check("shift");
  endtask

  task automatic pw(input logic [2:0] i, input logic [3:0] n);
    prog_controller_i.par_write(i, n);
    if (!cs_off) begin
      fr_q[5*i+4] = n[3];
      fr_q[5*i+3] = 1'h1;
      for (int b = 0; b < 3; b++) fr_q[5*i+b] = n[b];
    end
    check("parallel");
  endtask

  task automatic upd(input bit clr);
    prog_controller_i.strobe(clr);
    if (clr) foreach (r2_q[b]) r2_q[b] = 1'h0;
    else if (!cs_off) r2_q = fr_q;
    check("strobe");
  endtask

  task automatic levels(input bit cs, input bit u);
    prog_controller_i.levels(cs, u);
    cs_off  = cs;
    upd_low = !u;
  endtask

  // Second rank copies one edge after first rank settles
  task automatic settle();
    @(posedge clk_sys_i);
    if (!cs_off && upd_low) r2_q = fr_q;
    check("follow");
  endtask

  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt = error_cnt + 1;
      test_done();
    end
  end

  initial begin
    for (int i = 0; i < 40; i++) begin
      fr_q.push_back(1'h0);
      r2_q.push_back(1'h0);
    end
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'h1;
    check("reset");
    // Two full words: the first must ripple out of the second
    for (int w = 0; w < 2; w++) begin
      for (int k = 7; k >= 0; k--) begin
        rnd = lfsr(rnd);
        for (int b = 4; b >= 0; b--) begin
          sbit(b == 3 ? 1'h1 : rnd[b]);
        end
      end
    end
    upd(1'h0);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      pw(i[2:0], rnd[3:0]);
    end
    upd(1'h0);
    levels(1'h1, 1'h1);
    sbit(1'h1);
    pw(3'h7, 4'h5);
    upd(1'h0);
    upd(1'h1);
    levels(1'h0, 1'h1);
    upd(1'h0);
    levels(1'h0, 1'h0);
    pw(3'h2, 4'hB);
    settle();
    upd(1'h1);
    settle();
    test_done();
  end
endmodule

`default_nettype wire
